// >>> logic/fault_mask_top.sv
`timescale 1ns/1ps
`include "fault_mask_defines.svh"

// Contract
// (RQ1) Clear acts only on the same bit position
// (RQ2) Host clears flag after fault condition ends
// (RQ3) Groups one, three: alarm pins signal faults
// (RQ4) Groups zero, two: alarm regardless of masks
// (RQ5) Pin-maskable fault alarms only when unmasked
// (RQ6) Masked pin-maskable fault: no alarm, no safe
// (RQ7) Mask n gates safe mode of status n
// (RQ8) Mask bit one blocks safe; resets zero
// (RQ9) Pin-maskable: group1 bits 9,10; group3 0-5,7
// (RQ10) Group-two bits 0,1 are plain storage
// (RQ11) Group-two clear covers filter, driver, serial flags
// (RQ12) Filter overflow flags raise the alarm
// (RQ13) Group-three clear acts on group-three status
// (RQ14) Safe request: OR of unmasked valid status
module fault_mask_top (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [`FM_ADDR_W-1:0] reg_addr_i,
  input wire fault_mask_pkg::fault_word_t reg_wdata_i,
  output fault_mask_pkg::fault_word_t reg_rdata_o,
  output logic reg_ack_o,
  output logic reg_err_o,
  input wire fault_mask_pkg::fault_word_t status_group0_i,
  input wire fault_mask_pkg::fault_word_t status_group1_i,
  input wire fault_mask_pkg::fault_word_t status_group2_i,
  input wire fault_mask_pkg::fault_word_t status_group3_i,
  input wire fault_mask_pkg::fault_word_t mask_group3_i,
  output fault_mask_pkg::fault_word_t clr_group1_o,
  output fault_mask_pkg::fault_word_t clr_group2_o,
  output fault_mask_pkg::fault_word_t clr_group3_o,
  output logic fault_hi_o,
  output logic fault_lo_n_o,
  output logic safe_req_o
);

  // ****************************************************************
  // Register port decode
  // ****************************************************************
  fault_cfg_if cfg ();

  fault_mask_pkg::reg_sel_t wr_sel;
  fault_mask_pkg::reg_sel_t rd_sel;
  fault_mask_pkg::fault_word_t next_rdata;
  logic wr_hit;
  logic rd_hit;
  logic req;
  logic next_err;
  logic alarm_raw;
  logic safe_raw;

  assign wr_sel = fault_mask_pkg::addr_to_sel(reg_addr_i);
  assign rd_sel = fault_mask_pkg::addr_to_sel(reg_addr_i);
  assign wr_hit = reg_wr_i && (wr_sel != fault_mask_pkg::SEL_NONE);
  assign rd_hit = reg_rd_i && !reg_wr_i;
  // A write wins when both strobes come together
  assign req = reg_wr_i || reg_rd_i;
  assign next_err = req && (wr_sel == fault_mask_pkg::SEL_NONE);

  assign cfg.wr_en = wr_hit;
  assign cfg.wr_sel = wr_sel;
  assign cfg.wdata = reg_wdata_i;

  assign next_rdata =
    !rd_hit ? '0 :
    (rd_sel == fault_mask_pkg::SEL_CLR1) ? cfg.clr1 :
    (rd_sel == fault_mask_pkg::SEL_CLR2) ? cfg.clr2 :
    (rd_sel == fault_mask_pkg::SEL_CLR3) ? cfg.clr3 :
    (rd_sel == fault_mask_pkg::SEL_MASK0) ? cfg.mask0 :
    (rd_sel == fault_mask_pkg::SEL_MASK1) ? cfg.mask1 :
    (rd_sel == fault_mask_pkg::SEL_MASK2) ? cfg.mask2 : '0;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= '0;
      reg_ack_o <= 1'b0;
      reg_err_o <= 1'b0;
    end else begin
      reg_rdata_o <= next_rdata;
      reg_ack_o <= req;
      reg_err_o <= next_err;
    end
  end

  // ****************************************************************
  // Storage and gating
  // ****************************************************************
  fault_regs u_regs (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .cfg(cfg.store)
  );

  fault_combine u_combine (
    .status_group0_i(status_group0_i),
    .status_group1_i(status_group1_i),
    .status_group2_i(status_group2_i),
    .status_group3_i(status_group3_i),
    .mask_group3_i(mask_group3_i),
    .cfg(cfg.gate),
    .alarm_o(alarm_raw),
    .safe_o(safe_raw)
  );

  assign clr_group1_o = cfg.clr_pulse1; // RQ1
  assign clr_group2_o = cfg.clr_pulse2; // RQ11
  assign clr_group3_o = cfg.clr_pulse3; // RQ13

  // ****************************************************************
  // Alarm pins and safe-mode request
  // ****************************************************************
  // Registered so the pins never glitch while status words settle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fault_hi_o <= 1'b0;
      fault_lo_n_o <= 1'b1;
      safe_req_o <= 1'b0;
    end else begin
      fault_hi_o <= alarm_raw; // RQ3
      fault_lo_n_o <= !alarm_raw; // RQ3
      safe_req_o <= safe_raw; // RQ14
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_clear_group1: assert property ( // RQ1
    @(posedge clk_i) disable iff (!nrst_i)
    (reg_wr_i && reg_addr_i == `FM_ADDR_CLR1) |=>
      (clr_group1_o == $past(reg_wdata_i)) ##1 (clr_group1_o == '0
        || $past(reg_wr_i)))
    else $error("group one clear strobe wrong");

  a_clear_group2_rsvd: assert property ( // RQ10
    @(posedge clk_i) disable iff (!nrst_i)
    (reg_wr_i && reg_addr_i == `FM_ADDR_CLR2) |=>
      (clr_group2_o[1:0] == 2'h0) &&
      (clr_group2_o[15:2] == $past(reg_wdata_i[15:2])))
    else $error("group two clear strobe wrong");

  a_clear_group3: assert property ( // RQ13
    @(posedge clk_i) disable iff (!nrst_i)
    (reg_wr_i && reg_addr_i == `FM_ADDR_CLR3) |=>
      (clr_group3_o == $past(reg_wdata_i)) && (clr_group1_o == '0))
    else $error("group three clear strobe wrong");

  a_alarm_pin_pair: assert property ( // RQ3
    @(posedge clk_i) disable iff (!nrst_i)
    fault_hi_o == !fault_lo_n_o)
    else $error("alarm pins not complementary");

  a_alarm_group02: assert property ( // RQ4
    @(posedge clk_i) disable iff (!nrst_i)
    ((status_group0_i & `FM_VALID_G0) != '0 ||
     (status_group2_i & `FM_VALID_G2) != '0) |=>
      fault_hi_o && !fault_lo_n_o)
    else $error("group zero or two fault not on pins");

  a_alarm_plain_g1: assert property ( // RQ3
    @(posedge clk_i) disable iff (!nrst_i)
    ((status_group1_i & ~`FM_PINMASK_G1) != '0) |=> fault_hi_o)
    else $error("group one fault not on pins");

  a_pin_open_fires: assert property ( // RQ5
    @(posedge clk_i) disable iff (!nrst_i)
    ((status_group3_i & `FM_PINMASK_G3 & ~mask_group3_i) != '0) |=>
      fault_hi_o && safe_req_o)
    else $error("unmasked pin fault missed");

  a_pin_masked_quiet: assert property ( // RQ6
    @(posedge clk_i) disable iff (!nrst_i)
    ((status_group0_i & `FM_VALID_G0) == '0 &&
     (status_group2_i & `FM_VALID_G2) == '0 &&
     (status_group3_i & ~(mask_group3_i & `FM_PINMASK_G3)) == '0 &&
     (status_group1_i & ~(cfg.mask1 & `FM_PINMASK_G1)) == '0) |=>
      !fault_hi_o)
    else $error("masked pin fault drove the alarm");

  a_mask_blocks_safe: assert property ( // RQ7
    @(posedge clk_i) disable iff (!nrst_i)
    ((status_group0_i & ~cfg.mask0) == '0 &&
     (status_group1_i & ~cfg.mask1) == '0 &&
     (status_group2_i & ~cfg.mask2 & `FM_VALID_G2) == '0 &&
     (status_group3_i & ~mask_group3_i) == '0) |=> !safe_req_o)
    else $error("masked fault requested safe mode");

  a_mask_write_holds: assert property ( // RQ8
    @(posedge clk_i) disable iff (!nrst_i)
    (reg_wr_i && reg_addr_i == `FM_ADDR_MASK1) ##1 !reg_wr_i |->
      (cfg.mask1 == $past(reg_wdata_i)))
    else $error("mask write not stored");

  a_read_answer: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (reg_rd_i && !reg_wr_i && reg_addr_i == `FM_ADDR_MASK2) |=>
      reg_ack_o && !reg_err_o && (reg_rdata_o == cfg.mask2))
    else $error("mask read answer wrong");

  a_clear_idle_zero: assert property ( // RQ1
    @(posedge clk_i) disable iff (!nrst_i)
    !reg_wr_i |=>
      (clr_group1_o == '0) && (clr_group2_o == '0) &&
      (clr_group3_o == '0))
    else $error("clear strobe without a write");

  a_clear_group1_only: assert property ( // RQ1
    @(posedge clk_i) disable iff (!nrst_i)
    (reg_wr_i && reg_addr_i == `FM_ADDR_CLR1) |=>
      (clr_group2_o == '0) && (clr_group3_o == '0))
    else $error("group one clear reached another group");

  a_clear_group2_only: assert property ( // RQ11
    @(posedge clk_i) disable iff (!nrst_i)
    (reg_wr_i && reg_addr_i == `FM_ADDR_CLR2) |=>
      (clr_group1_o == '0) && (clr_group3_o == '0))
    else $error("group two clear reached another group");

  a_clear_word_kept: assert property ( // RQ10
    @(posedge clk_i) disable iff (!nrst_i)
    (reg_wr_i && reg_addr_i == `FM_ADDR_CLR2) |=>
      (cfg.clr2 == $past(reg_wdata_i)))
    else $error("group two clear word not stored");

  a_mask2_rsvd_kept: assert property ( // RQ10
    @(posedge clk_i) disable iff (!nrst_i)
    (reg_wr_i && reg_addr_i == `FM_ADDR_MASK2) |=>
      (cfg.mask2[1:0] == $past(reg_wdata_i[1:0])))
    else $error("group two mask reserved bits not stored");

  a_unmapped_ignored: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (reg_wr_i && (reg_addr_i < `FM_ADDR_CLR1 ||
                  reg_addr_i > `FM_ADDR_MASK2)) |=>
      (cfg.mask0 == $past(cfg.mask0)) && (cfg.mask1 == $past(cfg.mask1)) &&
      (cfg.mask2 == $past(cfg.mask2)) && reg_err_o)
    else $error("unmapped write changed state");

  a_read_unmapped: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (reg_rd_i && (reg_addr_i < `FM_ADDR_CLR1 ||
                  reg_addr_i > `FM_ADDR_MASK2)) |=>
      reg_ack_o && reg_err_o && (reg_rdata_o == '0))
    else $error("unmapped read answer wrong");

  a_idle_no_answer: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    !(reg_wr_i || reg_rd_i) |=>
      !reg_ack_o && !reg_err_o && (reg_rdata_o == '0))
    else $error("answer without a request");

  a_both_strobes: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (reg_wr_i && reg_rd_i) |=> reg_ack_o && (reg_rdata_o == '0))
    else $error("write with read strobe answered data");

  a_alarm_plain_g3: assert property ( // RQ3
    @(posedge clk_i) disable iff (!nrst_i)
    ((status_group3_i & ~`FM_PINMASK_G3) != '0) |=> fault_hi_o)
    else $error("group three fault not on pins");

  a_pin_open_g1: assert property ( // RQ5
    @(posedge clk_i) disable iff (!nrst_i)
    ((status_group1_i & `FM_PINMASK_G1 & ~cfg.mask1) != '0) |=>
      fault_hi_o && !fault_lo_n_o && safe_req_o)
    else $error("unmasked group one pin fault missed");

  a_safe_open_g0: assert property ( // RQ7
    @(posedge clk_i) disable iff (!nrst_i)
    ((status_group0_i & `FM_VALID_G0 & ~cfg.mask0) != '0) |=> safe_req_o)
    else $error("unmasked group zero fault missed safe mode");

  a_safe_open_g1: assert property ( // RQ7
    @(posedge clk_i) disable iff (!nrst_i)
    ((status_group1_i & ~cfg.mask1) != '0) |=> safe_req_o)
    else $error("unmasked group one fault missed safe mode");

  a_safe_open_g2: assert property ( // RQ7
    @(posedge clk_i) disable iff (!nrst_i)
    ((status_group2_i & `FM_VALID_G2 & ~cfg.mask2) != '0) |=> safe_req_o)
    else $error("unmasked group two fault missed safe mode");

  a_safe_open_g3: assert property ( // RQ14
    @(posedge clk_i) disable iff (!nrst_i)
    ((status_group3_i & ~mask_group3_i) != '0) |=> safe_req_o)
    else $error("unmasked group three fault missed safe mode");

  a_rsvd_quiet: assert property ( // RQ14
    @(posedge clk_i) disable iff (!nrst_i)
    (status_group1_i == '0 && status_group3_i == '0 &&
     (status_group0_i & `FM_VALID_G0) == '0 &&
     (status_group2_i & `FM_VALID_G2) == '0) |=>
      !fault_hi_o && fault_lo_n_o && !safe_req_o)
    else $error("reserved status bit raised an output");

  a_reset_values: assert property ( // RQ8
    @(posedge clk_i)
    (!nrst_i ##1 nrst_i) |->
      (cfg.mask0 == `FM_MASK_RST) && (cfg.mask1 == `FM_MASK_RST) &&
      (cfg.mask2 == `FM_MASK_RST) && (cfg.clr2 == `FM_CLR_RST) &&
      !fault_hi_o && fault_lo_n_o && !safe_req_o)
    else $error("state not at reset values after release");

endmodule : fault_mask_top

// >>> logic/fault_mask_defines.svh
`ifndef FAULT_MASK_DEFINES_SVH
`define FAULT_MASK_DEFINES_SVH

// ****************************************************************
// Register indices on the serial register port
// ****************************************************************
`define FM_ADDR_W 12
`define FM_ADDR_CLR1 12'h105
`define FM_ADDR_CLR2 12'h106
`define FM_ADDR_CLR3 12'h107
`define FM_ADDR_MASK0 12'h108
`define FM_ADDR_MASK1 12'h109
`define FM_ADDR_MASK2 12'h10a

// ****************************************************************
// Reset values and field layouts
// ****************************************************************
`define FM_CLR_RST 16'h0000
`define FM_MASK_RST 16'h0000
`define FM_PINMASK_G1 16'h0600
`define FM_PINMASK_G3 16'h00bf
`define FM_VALID_G0 16'h73fd
`define FM_VALID_G2 16'hfffc
`define FM_VALID_ALL 16'hffff

`endif

// >>> logic/fault_mask_pkg.sv
`include "fault_mask_defines.svh"

package fault_mask_pkg;

  typedef logic [15:0] fault_word_t;

  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_CLR1 = 3'b001,
    SEL_CLR2 = 3'b010,
    SEL_CLR3 = 3'b011,
    SEL_MASK0 = 3'b100,
    SEL_MASK1 = 3'b101,
    SEL_MASK2 = 3'b110
  } reg_sel_t;

  function automatic reg_sel_t addr_to_sel(
    input logic [`FM_ADDR_W-1:0] addr
  );
    reg_sel_t sel;
    case (addr)
      `FM_ADDR_CLR1: sel = SEL_CLR1;
      `FM_ADDR_CLR2: sel = SEL_CLR2;
      `FM_ADDR_CLR3: sel = SEL_CLR3;
      `FM_ADDR_MASK0: sel = SEL_MASK0;
      `FM_ADDR_MASK1: sel = SEL_MASK1;
      `FM_ADDR_MASK2: sel = SEL_MASK2;
      default: sel = SEL_NONE;
    endcase
    return sel;
  endfunction : addr_to_sel

  // Set when any valid status bit is not blocked by its gate
  function automatic logic any_open(
    input fault_word_t status,
    input fault_word_t block,
    input fault_word_t valid
  );
    return |(status & ~block & valid);
  endfunction : any_open

endpackage : fault_mask_pkg

// >>> logic/fault_cfg_if.sv
`timescale 1ns/1ps

interface fault_cfg_if;
  logic wr_en;
  fault_mask_pkg::reg_sel_t wr_sel;
  fault_mask_pkg::fault_word_t wdata;
  fault_mask_pkg::fault_word_t clr1;
  fault_mask_pkg::fault_word_t clr2;
  fault_mask_pkg::fault_word_t clr3;
  fault_mask_pkg::fault_word_t mask0;
  fault_mask_pkg::fault_word_t mask1;
  fault_mask_pkg::fault_word_t mask2;
  fault_mask_pkg::fault_word_t clr_pulse1;
  fault_mask_pkg::fault_word_t clr_pulse2;
  fault_mask_pkg::fault_word_t clr_pulse3;

  modport store (
    input wr_en, wr_sel, wdata,
    output clr1, clr2, clr3, mask0, mask1, mask2,
    output clr_pulse1, clr_pulse2, clr_pulse3
  );
  modport gate (
    input mask0, mask1, mask2
  );
endinterface : fault_cfg_if

// >>> logic/fault_regs.sv
`timescale 1ns/1ps
`include "fault_mask_defines.svh"

module fault_regs (
  input wire logic clk_i,
  input wire logic nrst_i,
  fault_cfg_if.store cfg
);

  logic hit_clr1;
  logic hit_clr2;
  logic hit_clr3;

  assign hit_clr1 = cfg.wr_en && (cfg.wr_sel == fault_mask_pkg::SEL_CLR1);
  assign hit_clr2 = cfg.wr_en && (cfg.wr_sel == fault_mask_pkg::SEL_CLR2);
  assign hit_clr3 = cfg.wr_en && (cfg.wr_sel == fault_mask_pkg::SEL_CLR3);

  // ****************************************************************
  // Stored words
  // ****************************************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg.clr1 <= `FM_CLR_RST;
      cfg.clr2 <= `FM_CLR_RST;
      cfg.clr3 <= `FM_CLR_RST;
      cfg.mask0 <= `FM_MASK_RST; // RQ8
      cfg.mask1 <= `FM_MASK_RST; // RQ8
      cfg.mask2 <= `FM_MASK_RST; // RQ8
    end else if (cfg.wr_en) begin
      case (cfg.wr_sel)
        fault_mask_pkg::SEL_CLR1: cfg.clr1 <= cfg.wdata;
        // Bits 1:0 are kept as plain storage
        fault_mask_pkg::SEL_CLR2: cfg.clr2 <= cfg.wdata; // RQ10
        fault_mask_pkg::SEL_CLR3: cfg.clr3 <= cfg.wdata;
        fault_mask_pkg::SEL_MASK0: cfg.mask0 <= cfg.wdata;
        fault_mask_pkg::SEL_MASK1: cfg.mask1 <= cfg.wdata;
        fault_mask_pkg::SEL_MASK2: cfg.mask2 <= cfg.wdata; // RQ10
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // One-cycle clear strobes, one bit per status position
  // ****************************************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg.clr_pulse1 <= `FM_CLR_RST;
      cfg.clr_pulse2 <= `FM_CLR_RST;
      cfg.clr_pulse3 <= `FM_CLR_RST;
    end else begin
      cfg.clr_pulse1 <= hit_clr1 ? cfg.wdata : `FM_CLR_RST; // RQ1
      // Reserved positions carry no fault, so they never strobe
      cfg.clr_pulse2 <= hit_clr2 ? (cfg.wdata & `FM_VALID_G2) :
                                   `FM_CLR_RST; // RQ11
      cfg.clr_pulse3 <= hit_clr3 ? cfg.wdata : `FM_CLR_RST; // RQ13
    end
  end

endmodule : fault_regs

// >>> logic/fault_combine.sv
`timescale 1ns/1ps
`include "fault_mask_defines.svh"

module fault_combine (
  input wire fault_mask_pkg::fault_word_t status_group0_i,
  input wire fault_mask_pkg::fault_word_t status_group1_i,
  input wire fault_mask_pkg::fault_word_t status_group2_i,
  input wire fault_mask_pkg::fault_word_t status_group3_i,
  input wire fault_mask_pkg::fault_word_t mask_group3_i,
  fault_cfg_if.gate cfg,
  output logic alarm_o,
  output logic safe_o
);

  fault_mask_pkg::fault_word_t pin_block1;
  fault_mask_pkg::fault_word_t pin_block3;
  logic alarm_g02;
  logic alarm_g1;
  logic alarm_g3;

  // Only pin-maskable positions let the mask reach the alarm pins
  assign pin_block1 = cfg.mask1 & `FM_PINMASK_G1; // RQ9
  assign pin_block3 = mask_group3_i & `FM_PINMASK_G3; // RQ9

  assign alarm_g02 =
    fault_mask_pkg::any_open(status_group0_i, '0, `FM_VALID_G0) ||
    fault_mask_pkg::any_open(status_group2_i, '0, `FM_VALID_G2); // RQ4 RQ12
  assign alarm_g1 = fault_mask_pkg::any_open(status_group1_i, pin_block1,
                                             `FM_VALID_ALL); // RQ3 RQ5 RQ6
  assign alarm_g3 = fault_mask_pkg::any_open(status_group3_i, pin_block3,
                                             `FM_VALID_ALL); // RQ3 RQ5 RQ6
  assign alarm_o = alarm_g02 || alarm_g1 || alarm_g3;

  assign safe_o =
    fault_mask_pkg::any_open(status_group0_i, cfg.mask0, `FM_VALID_G0) ||
    fault_mask_pkg::any_open(status_group1_i, cfg.mask1, `FM_VALID_ALL) ||
    fault_mask_pkg::any_open(status_group2_i, cfg.mask2, `FM_VALID_G2) ||
    fault_mask_pkg::any_open(status_group3_i, mask_group3_i,
                             `FM_VALID_ALL); // RQ7 RQ14

endmodule : fault_combine

// >>> bench/fault_status_model.sv
`timescale 1ns/1ps

// ****************************************************************
// External latched status for groups one to three, set by raw faults, cleared by strobes
// ****************************************************************
module fault_status_model (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire fault_mask_pkg::fault_word_t [3:0] raw_i,
  input wire fault_mask_pkg::fault_word_t [3:1] clr_i,
  output fault_mask_pkg::fault_word_t [3:0] status_o
);
  fault_mask_pkg::fault_word_t [3:1] lat;

  // Group zero has no clear strobe here, so it just follows the raw fault
  assign status_o = {lat, raw_i[0]};

  // Set wins over clear, so a live fault survives an early clear
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lat <= '0;
    end else begin
      for (int g = 1; g < 4; g++) begin
        lat[g] <= (lat[g] & ~clr_i[g]) | raw_i[g];
      end
    end
  end
endmodule : fault_status_model

// >>> bench/fault_clear_and_safe_mode_mask_test.sv
`timescale 1ns/1ps
`include "fault_mask_defines.svh"

module fault_clear_and_safe_mode_mask_test;
  logic clk_i, nrst_i, wr, rd, ack, err, hi, lo_n, safe;
  logic [`FM_ADDR_W-1:0] addr;
  fault_mask_pkg::fault_word_t wdata, rdata, mask3, old, c;
  fault_mask_pkg::fault_word_t [3:0] raw, st;
  wire fault_mask_pkg::fault_word_t [3:1] clr;
  fault_mask_pkg::fault_word_t [2:0] msk;
  int err_total, n_compared;
  logic [31:0] seed;

  fault_mask_top dut (.clk_i(clk_i), .nrst_i(nrst_i), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .reg_ack_o(ack), .reg_err_o(err),
    .status_group0_i(st[0]), .status_group1_i(st[1]),
    .status_group2_i(st[2]), .status_group3_i(st[3]),
    .mask_group3_i(mask3), .clr_group1_o(clr[1]),
    .clr_group2_o(clr[2]), .clr_group3_o(clr[3]),
    .fault_hi_o(hi), .fault_lo_n_o(lo_n), .safe_req_o(safe));

  fault_status_model model (.clk_i(clk_i), .nrst_i(nrst_i),
    .raw_i(raw), .clr_i(clr), .status_o(st));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One register access; writes return zero read data
  task automatic acc(input logic w, input logic [11:0] a,
                     input logic [15:0] d, input logic [15:0] exp);
    logic bad;
    bad = (a < `FM_ADDR_CLR1) || (a > `FM_ADDR_MASK2);
    @(posedge clk_i);
    #1;
    wr = w;
    rd = !w;
    addr = a;
    wdata = d;
    @(posedge clk_i);
    #1;
    wr = 1'b0;
    rd = 1'b0;
    chk(16'(ack), 16'h0001);
    chk(16'(err), 16'(bad));
    chk(rdata, exp);
    if (w) begin
      chk(clr[1], (a == `FM_ADDR_CLR1) ? d : 16'h0000);
      chk(clr[2], (a == `FM_ADDR_CLR2) ? (d & 16'hfffc) : 16'h0000);
      chk(clr[3], (a == `FM_ADDR_CLR3) ? d : 16'h0000);
      if (!bad && a >= `FM_ADDR_MASK0) begin
        msk[a - `FM_ADDR_MASK0] = d;
      end
    end
  endtask : acc

  task automatic check_pins();
    logic a, s;
    repeat (3) @(posedge clk_i);
    #1;
    a = |(st[0] & `FM_VALID_G0) | |(st[2] & `FM_VALID_G2)
      | |(st[1] & ~(msk[1] & `FM_PINMASK_G1))
      | |(st[3] & ~(mask3 & `FM_PINMASK_G3));
    s = |(st[0] & ~msk[0] & `FM_VALID_G0) | |(st[1] & ~msk[1])
      | |(st[2] & ~msk[2] & `FM_VALID_G2) | |(st[3] & ~mask3);
    chk(16'(hi), 16'(a));
    chk(16'(lo_n), 16'(!a));
    chk(16'(safe), 16'(s));
  endtask : check_pins

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end

  initial begin
    seed = 32'h0000_4125;
    {wr, rd, nrst_i} = 3'b000;
    addr = '0;
    wdata = '0;
    raw = '0;
    mask3 = '0;
    msk = '0;
    err_total = 0;
    n_compared = 0;
    repeat (2) @(posedge clk_i);
    #1;
    nrst_i = 1'b1;
    for (int i = 0; i < 6; i++) begin
      acc(1'b0, `FM_ADDR_CLR1 + 12'(i), 16'h0000, 16'h0000);
    end
    acc(1'b0, 12'h10b, 16'h0000, 16'h0000);
    acc(1'b1, 12'h104, 16'hffff, 16'h0000);
    $display("test reset and unmapped done");
    raw[1] = 16'h0200;
    check_pins();
    acc(1'b1, `FM_ADDR_MASK1, 16'h0300, 16'h0000);
    check_pins();
    raw[1] = 16'h0300;
    check_pins();
    // Host drops the fault before clearing it
    raw[1] = 16'h0000;
    acc(1'b1, `FM_ADDR_CLR1, 16'h0100, 16'h0000);
    @(posedge clk_i);
    #1;
    chk(st[1], 16'h0200);
    check_pins();
    raw[0] = 16'h8c02;
    raw[2] = 16'h0003;
    check_pins();
    acc(1'b1, `FM_ADDR_MASK2, 16'hffff, 16'h0000);
    raw[2] = 16'h0004;
    check_pins();
    $display("test pin masking done");
    for (int n = 0; n < 40; n++) begin
      for (int g = 0; g < 3; g++) begin
        c = 16'(rnd());
        acc(1'b1, `FM_ADDR_MASK0 + 12'(g), c, 16'h0000);
        acc(1'b0, `FM_ADDR_MASK0 + 12'(g), 16'h0000, c);
      end
      mask3 = 16'(rnd());
      for (int g = 0; g < 4; g++) begin
        raw[g] = 16'(rnd() & rnd());
      end
      check_pins();
      raw = '0;
      for (int g = 1; g < 4; g++) begin
        old = st[g];
        c = 16'(rnd());
        acc(1'b1, `FM_ADDR_CLR1 + 12'(g - 1), c, 16'h0000);
        @(posedge clk_i);
        #1;
        chk(st[g], old & ~(c & ((g == 2) ? 16'hfffc : 16'hffff)));
        acc(1'b0, `FM_ADDR_CLR1 + 12'(g - 1), 16'h0000, c);
      end
      check_pins();
    end
    $display("test random traffic done");
    // Reset again in mid-run: every stored word must read back as zero
    @(posedge clk_i);
    #1;
    nrst_i = 1'b0;
    msk = '0;
    repeat (2) @(posedge clk_i);
    #1;
    nrst_i = 1'b1;
    chk(16'({hi, lo_n, safe}), 16'h0002);
    for (int i = 0; i < 6; i++) begin
      acc(1'b0, `FM_ADDR_CLR1 + 12'(i), 16'h0000, 16'h0000);
    end
    // Both strobes together: the write lands, no data comes back
    @(posedge clk_i);
    #1;
    {wr, rd} = 2'b11;
    addr = `FM_ADDR_MASK0;
    wdata = 16'h5a5a;
    @(posedge clk_i);
    #1;
    {wr, rd} = 2'b00;
    chk(16'({ack, err}), 16'h0002);
    chk(rdata, 16'h0000);
    acc(1'b0, `FM_ADDR_MASK0, 16'h0000, 16'h5a5a);
    $display("test reset again and both strobes done");
    print_verdict();
  end
endmodule : fault_clear_and_safe_mode_mask_test
